// ---- sdcd_core.sv ----
/*
  Command interpreter of the drive: power-mode query answer, microcode
  download refusal, streaming and error-recovery time limits, and the
  link reset answer. Assumes commands arrive as one-cycle strobes with
  their parameters valid in the same cycle; the power-on reset is sys_rst.
*/
// Function
// R1 - with extended power conditions off the power-mode query answers FFh in the count instead of 80h.
// R2 - a link reset is handled differently from power-on: it aborts the command but keeps power-on state.
// R3 - both microcode download forms are aborted while security is locked.
// R4 - within 500 ms of power-on the cominit answer to a link reset may be later than 10 ms.
// R5 - in standby a streaming command does not complete before the spindle is at speed.
// R6 - a streaming completion limit under 50 ms is raised to 50 ms.
// R7 - in standby a command with an error-recovery limit waits for the spindle before completing.
// R8 - an error-recovery limit under 6.5 s aborts the command.
// R9 - the host sets busy and sends a frame on command write, soft reset change or link reset request; the host model sends no frame on a soft reset change.

`timescale 1ns/1ps

module sdcd_core import sdcd_pkg::*; #(
  parameter int unsigned TICK_CYC = MS_CYC               // cycles per ms
) (
  input  wire logic       mclk,             // 10 MHz clock
  input  wire logic       sys_rst,          // power-on reset, sync high
  input  wire logic       cmd_strobe,       // new command frame (host side)
  input  wire logic [7:0] cmd_code,         // command code
  input  wire logic [15:0] cmd_cctl_ms,     // completion limit, ms
  input  wire logic       cmd_erc_en,       // error-recovery limit given
  input  wire logic [15:0] cmd_erc_limit,   // recovery limit, 100 ms units
  input  wire logic       epc_enabled,      // extended power conditions on
  input  wire logic       security_locked,  // security locked mode
  input  wire logic       standby_mode,     // drive in standby
  input  wire logic       spindle_at_speed, // spindle at operating speed
  input  wire logic       comreset_req,     // link reset received
  output logic            cmd_busy,         // command in progress
  output logic            cmd_done,         // completion pulse
  output logic            cmd_abort,        // abort flag with done
  output logic            cmd_late,         // finished past its limit
  output logic [7:0]      sect_count,       // count register answer
  output logic            cominit_out,      // cominit pulse
  output logic            link_rst_seen     // last reset was a link reset
);
  import sdcd_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SDCD_IDLE = 2'b01,
    SDCD_EXEC = 2'b10
  } sdcd_st_t;

  typedef struct packed {
    sdcd_st_t          st;
    logic              wait_spin;  // spin-up hold latched at issue
    logic [MSW-1:0]    lim_ms;     // effective limit in ms
    logic [MSW-1:0]    run_ms;     // elapsed ms of the command
    logic              busy;
    logic              done;
    logic              abort;
    logic              late;
    logic [7:0]        sc;
    logic              por_win;    // inside slow cominit window
    logic [9:0]        por_ms;
    logic              cr_pend;
    logic [CRW-1:0]    cr_cnt;
    logic              cominit;
    logic              link_rst;
  } sdcd_state_t;

  sdcd_state_t s_q, s_d;
  logic        tick;
  logic        is_stream;
  logic        is_dl;

  sdcd_ms_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick_q  (tick)
  );

  assign is_stream = (cmd_code == CMD_RD_STREAM) || (cmd_code == CMD_WR_STREAM);
  assign is_dl     = (cmd_code == CMD_DL_PIO) || (cmd_code == CMD_DL_DMA);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    s_d.cominit = 1'b0;
    // power-on window counts only after sys_rst, never after a link reset
    if (s_q.por_win && tick) begin // R4
      s_d.por_ms = s_q.por_ms + 10'h001;
      if (s_q.por_ms == 10'(POR_WIN_MS - 1)) begin
        s_d.por_win = 1'b0;
      end
    end
    // command sequencing; strobes are frames sent by the host
    case (s_q.st) // R9
      SDCD_IDLE: begin
        if (cmd_strobe) begin
          s_d.abort = 1'b0;
          s_d.late  = 1'b0;
          s_d.run_ms = '0;
          if (is_dl && security_locked) begin
            s_d.done  = 1'b1; // R3
            s_d.abort = 1'b1; // R3
          end else if (cmd_erc_en && (cmd_erc_limit < ERC_MIN_100MS)) begin
            s_d.done  = 1'b1; // R8
            s_d.abort = 1'b1; // R8
          end else if (cmd_code == CMD_CHK_PWR) begin
            s_d.done = 1'b1;
            if (standby_mode) begin
              s_d.sc = PWR_STANDBY;
            end else if (epc_enabled) begin
              s_d.sc = PWR_EPC_IDLE;
            end else begin
              s_d.sc = PWR_ACTIVE; // R1
            end
          end else begin
            s_d.st        = SDCD_EXEC;
            s_d.busy      = 1'b1;
            s_d.wait_spin = standby_mode;
            if (is_stream) begin
              s_d.lim_ms = (cmd_cctl_ms < CCTL_MIN_MS) ? CCTL_MIN_MS : cmd_cctl_ms; // R6
            end else if (cmd_erc_en) begin
              s_d.lim_ms = MSW'({cmd_erc_limit, 7'h00} - {cmd_erc_limit, 5'h00}
                                + {cmd_erc_limit, 2'h0});
            end else begin
              s_d.lim_ms = '1;
            end
          end
        end
      end
      SDCD_EXEC: begin
        if (tick && (s_q.run_ms != '1)) begin
          s_d.run_ms = s_q.run_ms + 16'h0001;
        end
        // completion waits for spin-up even past the limit
        if (!s_q.wait_spin || spindle_at_speed) begin // R5 R7
          s_d.st   = SDCD_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.sc   = SC_RESET;
          s_d.late = (s_q.run_ms >= s_q.lim_ms);
        end
      end
      default: begin
        s_d.st = SDCD_IDLE;
      end
    endcase
    // link reset: drop the command, keep power-on state and window
    if (comreset_req) begin // R2
      s_d.st       = SDCD_IDLE;
      s_d.busy     = 1'b0;
      s_d.done     = 1'b0;
      s_d.abort    = 1'b0;
      s_d.link_rst = 1'b1;
      s_d.cr_pend  = 1'b1;
      s_d.cr_cnt   = '0;
    end else if (s_q.cr_pend && !s_q.por_win) begin // R4
      s_d.cr_cnt = s_q.cr_cnt + 5'h01;
      if (s_q.cr_cnt == CRW'(CR_RESP_CYC - 1)) begin
        s_d.cr_pend = 1'b0;
        s_d.cominit = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.st      <= SDCD_IDLE;
      s_q.sc      <= SC_RESET;
      s_q.por_win <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_busy      = s_q.busy;
  assign cmd_done      = s_q.done;
  assign cmd_abort     = s_q.abort;
  assign cmd_late      = s_q.late;
  assign sect_count    = s_q.sc;
  assign cominit_out   = s_q.cominit;
  assign link_rst_seen = s_q.link_rst;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence issue_idle;
    s_q.st == SDCD_IDLE && cmd_strobe && !comreset_req;
  endsequence

  chk_pwr_epc_off: assert property (issue_idle and (cmd_code == CMD_CHK_PWR && !standby_mode && !epc_enabled && // R1
    !security_locked && !cmd_erc_en) |=> cmd_done && sect_count == PWR_ACTIVE)
    else $error("power query without epc did not answer FFh");
  chk_pwr_epc_on: assert property (issue_idle and (cmd_code == CMD_CHK_PWR && !standby_mode && epc_enabled && // R1
    !security_locked && !cmd_erc_en) |=> cmd_done && sect_count == PWR_EPC_IDLE)
    else $error("power query with epc did not answer 80h");
  chk_link_keeps_por: assert property (comreset_req && !s_q.por_win |=> !s_q.por_win && link_rst_seen && !cmd_busy) // R2
    else $error("link reset acted like power-on");
  chk_dl_locked: assert property (issue_idle and (is_dl && security_locked) |=> cmd_done && cmd_abort) // R3
    else $error("download not aborted while locked");
  chk_cominit_window: assert property (s_q.por_win |-> !cominit_out) // R4
    else $error("cominit inside power-on window");
  chk_cominit_fast: assert property (comreset_req && !s_q.por_win ##1 !comreset_req [*8] // R4
    |-> ##[1:12] cominit_out)
    else $error("cominit late outside power-on window");
  chk_stream_hold: assert property (s_q.st == SDCD_EXEC && s_q.wait_spin && !spindle_at_speed && !comreset_req // R5
    |=> !cmd_done && cmd_busy)
    else $error("command finished before spin-up");
  chk_cctl_floor: assert property (issue_idle and (is_stream && !is_dl && !cmd_erc_en && // R6
    cmd_cctl_ms < CCTL_MIN_MS && cmd_code != CMD_CHK_PWR) |=> s_q.lim_ms == CCTL_MIN_MS)
    else $error("completion limit not raised to 50 ms");
  // only a completion out of exec counts, the latched hold bit lingers in idle
  chk_erc_wait: assert property ($rose(cmd_done) && ($past(s_q.st) == SDCD_EXEC) && $past(s_q.wait_spin) // R7
    |-> $past(spindle_at_speed))
    else $error("recovery command finished before spin-up");
  chk_erc_short: assert property (issue_idle and (cmd_erc_en && cmd_erc_limit < ERC_MIN_100MS) // R8
    |=> cmd_done && cmd_abort ##1 !cmd_done)
    else $error("short recovery limit not aborted");
endmodule

// ---- sdcd_host_model.sv ----
/*
  Host adapter model with a shadow busy bit, facing the command interpreter.
  Assumes the bench raises request pulses at the falling edge, one cycle long except a two-cycle repeat of the device control write.
*/
`timescale 1ns/1ps
module sdcd_host_model (
  input  wire logic mclk,         // system clock
  input  wire logic sys_rst,      // sync reset
  input  wire logic cmd_wr,       // command register written
  input  wire logic dc_wr,        // device control written
  input  wire logic srst_bit,     // soft reset bit of that write
  input  wire logic lrst_wr,      // link reset requested
  input  wire logic dev_done,     // device completion
  input  wire logic dev_cominit,  // device link answer
  output logic      cmd_strobe,   // command frame to device
  output logic      comreset_req, // link reset to device
  output logic      shadow_bsy    // shadow status busy
);
  logic srst_q;  // soft reset bit last written
  // frames leave in the cycle of the write
  assign cmd_strobe   = cmd_wr;
  assign comreset_req = lrst_wr;
  // busy raised by any frame cause, dropped by the device's answer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shadow_bsy <= 1'b0;
      srst_q     <= 1'b0;
    end else begin
      if (dc_wr)
        srst_q <= srst_bit;
      if (cmd_wr || lrst_wr || (dc_wr && srst_bit != srst_q))
        shadow_bsy <= 1'b1;
      else if (dev_done || dev_cominit)
        shadow_bsy <= 1'b0;
    end
  end
endmodule

// ---- sdcd_ms_tick.sv ----
/*
  Package of shared constants for the drive command deviation block,
  and the millisecond enable divider used by the command interpreter.
  Assumes a single 10 MHz clock and a synchronous active high reset.
*/

// ------------------------------------------------------------
// shared constants
// ------------------------------------------------------------
package sdcd_pkg;
  localparam int unsigned CLK_HZ         = 10_000_000;     // mclk rate
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned MS_CYC         = CLK_HZ / MS_PER_S; // cycles per ms
  localparam int unsigned POR_WIN_MS     = 500;            // slow cominit window after power-on
  localparam int unsigned CR_LIMIT_MS    = 10;             // normal cominit answer limit
  localparam int unsigned CR_RESP_CYC    = 16;             // our cominit delay, far below limit
  localparam logic [15:0] CCTL_MIN_MS    = 16'h0032;       // 50 ms completion limit floor
  localparam logic [15:0] ERC_MIN_100MS  = 16'h0041;       // 6.5 s in 100 ms units
  localparam logic [7:0]  CMD_CHK_PWR    = 8'hE5;          // power-mode query
  localparam logic [7:0]  CMD_DL_PIO     = 8'h92;          // microcode download
  localparam logic [7:0]  CMD_DL_DMA     = 8'h93;          // microcode download, dma form
  localparam logic [7:0]  CMD_RD_STREAM  = 8'h2A;          // streaming read
  localparam logic [7:0]  CMD_WR_STREAM  = 8'h3A;          // streaming write
  localparam logic [7:0]  PWR_STANDBY    = 8'h00;          // count answer in standby
  localparam logic [7:0]  PWR_EPC_IDLE   = 8'h80;          // answer with epc enabled
  localparam logic [7:0]  PWR_ACTIVE     = 8'hFF;          // answer with epc disabled
  localparam logic [7:0]  SC_RESET       = 8'h00;
  localparam int unsigned MSW            = 16;             // ms counter width
  localparam int unsigned CRW            = 5;              // cominit delay counter width
endpackage

`timescale 1ns/1ps

// ------------------------------------------------------------
// millisecond enable divider
// ------------------------------------------------------------
module sdcd_ms_tick #(
  parameter int unsigned TICK_CYC = sdcd_pkg::MS_CYC     // cycles per tick
) (
  input  wire logic mclk,     // system clock
  input  wire logic sys_rst,  // synchronous reset
  output logic      tick_q    // one-cycle pulse per ms
);
  import sdcd_pkg::*;

  logic [23:0] cnt_q;

  // free running divider, pulses on wrap
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q  <= 24'h000000;
      tick_q <= 1'b0;
    end else if (cnt_q == 24'(TICK_CYC - 1)) begin
      cnt_q  <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end
endmodule

// ---- tb_top.sv ----
/*
  Self-checking bench of the command interpreter, driven through the host model.
  Assumes a 10 MHz clock and a millisecond of 10 cycles (TICK_CYC = 10).
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import sdcd_pkg::*;
  typedef struct {logic [7:0] c; logic [15:0] cc; logic ee; logic [15:0] el; logic ep; logic lk; int lat; logic ab;
    logic [7:0] sc;} sdcd_row_t;
  logic        mclk = 1'b0, sys_rst = 1'b1, cmd_wr = 1'b0, lrst_wr = 1'b0, cmd_strobe, comreset_req, shadow_bsy;
  logic [7:0]  cmd_code = 8'h00, sect_count;
  logic [15:0] cmd_cctl_ms = 16'h0000, cmd_erc_limit = 16'h0000;
  logic        cmd_erc_en = 1'b0, epc_enabled = 1'b0, security_locked = 1'b0, standby_mode = 1'b0;
  logic        spindle_at_speed = 1'b0, cmd_busy, cmd_done, cmd_abort, cmd_late, cominit_out, link_rst_seen;
  logic        dc_wr = 1'b0, srst_bit = 1'b0;
  int          error_cnt = 0, cmp_count = 0, n, i;
  sdcd_row_t   rows [9] = '{
    '{8'hE5, 16'h0064, 1'b0, 16'h0000, 1'b0, 1'b0, 1, 1'b0, 8'hFF}, '{8'hE5, 16'h0064, 1'b0, 16'h0000, 1'b1, 1'b0, 1, 1'b0, 8'h80},
    // aborts leave the count answer of the previous command in place
    '{8'h92, 16'h0064, 1'b0, 16'h0000, 1'b0, 1'b1, 1, 1'b1, 8'h80}, '{8'h93, 16'h0064, 1'b0, 16'h0000, 1'b0, 1'b1, 1, 1'b1, 8'h80},
    '{8'h93, 16'h0064, 1'b0, 16'h0000, 1'b0, 1'b0, 2, 1'b0, 8'h00}, '{8'h2A, 16'h0000, 1'b0, 16'h0000, 1'b0, 1'b0, 2, 1'b0, 8'h00},
    '{8'h3A, 16'h0031, 1'b0, 16'h0000, 1'b0, 1'b0, 2, 1'b0, 8'h00}, '{8'h2A, 16'h0064, 1'b1, 16'h0040, 1'b0, 1'b0, 1, 1'b1, 8'h00},
    '{8'h3A, 16'h0064, 1'b1, 16'h0041, 1'b0, 1'b0, 2, 1'b0, 8'h00}};
  always #50 mclk = ~mclk;  // 100 ns period
  sdcd_host_model host_u (.mclk, .sys_rst, .cmd_wr, .dc_wr, .srst_bit, .lrst_wr, .dev_done(cmd_done),
    .dev_cominit(cominit_out), .cmd_strobe, .comreset_req, .shadow_bsy);
  sdcd_core #(.TICK_CYC(10)) dut_u (.mclk, .sys_rst, .cmd_strobe, .cmd_code, .cmd_cctl_ms, .cmd_erc_en, .cmd_erc_limit,
    .epc_enabled, .security_locked, .standby_mode, .spindle_at_speed, .comreset_req, .cmd_busy, .cmd_done,
    .cmd_abort, .cmd_late, .sect_count, .cominit_out, .link_rst_seen);
  // print counts and verdict, end the run
  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // raise a command write with its parameters
  task automatic issue(input logic [7:0] c, input logic [15:0] cc, input logic ee, input logic [15:0] el);
    @(negedge mclk);
    {cmd_code, cmd_cctl_ms, cmd_erc_en, cmd_erc_limit, cmd_wr} = {c, cc, ee, el, 1'b1};
  endtask
  // count falling edges until done (sel 0) or cominit (sel 1), bounded
  task automatic wait_ev(input int lim, input bit sel, output int k);
    k = 0;
    do begin
      @(negedge mclk);
      {cmd_wr, lrst_wr} = 2'b00;
      k++;
    end while ((sel ? cominit_out : cmd_done) !== 1'b1 && k < lim);
    if (k >= lim) begin
      error_cnt++;
      $display("ERROR wait expected event seen none");
      stop_test();
    end
  endtask
  // no completion may show for a number of cycles
  task automatic hold_off(input int cyc);
    repeat (cyc) begin
      @(negedge mclk);
      cmd_wr = 1'b0;
      `CHK("no_done", 1'b0, cmd_done)
    end
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    `CHK("idle", 14'h0000, {cmd_busy, cmd_done, cmd_abort, cmd_late, cominit_out, link_rst_seen, sect_count})
    lrst_wr = 1'b1;
    wait_ev(6000, 1'b1, n);
    `CHK("slow_cominit", 1'b1, n > 17)
    `CHK("link_seen", 1'b1, link_rst_seen)
    // table of ordinary commands
    for (i = 0; i < 9; i++) begin
      {epc_enabled, security_locked} = {rows[i].ep, rows[i].lk};
      issue(rows[i].c, rows[i].cc, rows[i].ee, rows[i].el);
      wait_ev(50, 1'b0, n);
      `CHK("latency", rows[i].lat, n)
      `CHK("abort", rows[i].ab, cmd_abort)
      `CHK("count", rows[i].sc, sect_count)
      `CHK("late", 1'b0, cmd_late)
      `CHK("shadow_bsy", 1'b1, shadow_bsy)
    end
    // standby streaming waits for spindle past its 50 ms floor
    standby_mode = 1'b1;
    issue(8'h2A, 16'h0000, 1'b0, 16'h0000);
    hold_off(700);
    spindle_at_speed = 1'b1;
    wait_ev(5, 1'b0, n);
    `CHK("stby_late", 2'b10, {cmd_late, cmd_abort})
    spindle_at_speed = 1'b0;
    issue(8'h92, 16'h0064, 1'b1, 16'h0041);
    hold_off(100);
    spindle_at_speed = 1'b1;
    wait_ev(5, 1'b0, n);
    `CHK("stby_erc", 1'b0, cmd_abort)
    // link reset drops a waiting command, keeps power-on window spent
    spindle_at_speed = 1'b0;
    issue(8'h3A, 16'h0064, 1'b0, 16'h0000);
    hold_off(5);
    lrst_wr = 1'b1;
    wait_ev(40, 1'b1, n);
    `CHK("cominit_17", 17, n)
    `CHK("dropped", 2'b01, {cmd_busy, link_rst_seen})
    spindle_at_speed = 1'b1;
    hold_off(5);
    // soft reset bit change raises shadow busy, a repeat of the same bit does not
    {dc_wr, srst_bit} = 2'b11;
    hold_off(1);
    dc_wr = 1'b0;
    `CHK("srst_bsy", 1'b1, shadow_bsy)
    issue(8'hE5, 16'h0064, 1'b0, 16'h0000);
    wait_ev(5, 1'b0, n);
    `CHK("stby_pwr", 8'h00, sect_count)
    dc_wr = 1'b1;
    hold_off(2);
    dc_wr = 1'b0;
    `CHK("srst_same", 1'b0, shadow_bsy)
    stop_test();
  end
endmodule
